// file: reset_source_defs.svh
// register offsets, bit positions and timing counts for the reset source controller
`ifndef RESET_SOURCE_DEFS_SVH
`define RESET_SOURCE_DEFS_SVH

`define SUPPLY_MONITOR_CONTROL_ADDR 8'hFF
`define RESET_CAUSE_REGISTER_ADDR   8'hEF

`define SMC_ENABLE_BIT   7
`define SMC_STATUS_BIT   6

`define RC_PIN_BIT       0
`define RC_POWER_ON_BIT  1
`define RC_CLOCK_LOSS_BIT 2
`define RC_WATCHDOG_BIT  3
`define RC_SOFTWARE_BIT  4
`define RC_COMPARATOR_BIT 5
`define RC_MEMORY_BIT    6
`define RC_BUS_BIT       7

`define WATCHDOG_CLOCK_DIVIDE 12
`define RESET_HOLD_CYCLES     4
`define CLOCK_PERIOD_NS       50
`define MISSING_CLOCK_TIMEOUT_NS 500
`define MISSING_CLOCK_CYCLES  ((`MISSING_CLOCK_TIMEOUT_NS) / (`CLOCK_PERIOD_NS))

`endif

// file: reset_source_pkg.sv
// types shared by the reset source controller
package reset_source_pkg;

	typedef struct packed {
		logic       write_strobe;
		logic       read_strobe;
		logic [7:0] address;
		logic [7:0] write_data;
	} register_access_t;

	typedef struct packed {
		logic pin;
		logic power_on;
		logic clock_loss;
		logic watchdog;
		logic software;
		logic comparator;
		logic memory;
		logic bus;
	} reset_cause_t;

	typedef enum logic [1:0] {
		SEQ_RUN,
		SEQ_HOLD,
		SEQ_RELEASE
	} sequence_state_t;

endpackage

// file: reset_source_controller.sv
// reset source gathering, cause recording and supply monitor control
`timescale 1ns/1ns
`include "reset_source_defs.svh"

module reset_source_controller
	import reset_source_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES   = `RESET_HOLD_CYCLES,
	parameter int unsigned TIMEOUT_TICKS = `MISSING_CLOCK_CYCLES
) (
	input  wire logic                              CLOCK,             // system clock, 20 MHz
	input  wire logic                              RST_B,             // synchronous power-on reset, active low
	input  wire reset_source_pkg::register_access_t REG_ACCESS,       // register bus request
	output      logic [7:0]                        REG_READ_DATA,     // registered read data
	input  wire logic                              RESET_PIN_B_IN,    // level seen on external reset pin
	output      logic                              RESET_PIN_B_OUT,   // drive value for reset pin
	output      logic                              RESET_PIN_OE_B,    // low while pin is driven
	input  wire logic                              CLOCK_ACTIVITY,    // clock heartbeat from oscillator
	input  wire logic                              SUPPLY_ABOVE_THRESHOLD, // monitor output
	input  wire logic                              COMPARATOR_OUTPUT, // comparator output, low requests reset
	input  wire logic                              WATCHDOG_OVERFLOW, // unserviced watchdog pulse
	input  wire logic                              MEMORY_ACCESS_ERROR, // code access beyond user limit
	input  wire logic                              BUS_RESET_SIGNALLING, // bus reset seen on the link
	input  wire logic                              BUS_CONTROLLER_ENABLED, // function controller on
	input  wire logic                              VBUS_LEVEL,        // vbus detector level
	input  wire logic                              VBUS_EDGE_POLARITY, // 1 rising, 0 falling
	output      logic                              SYSTEM_RESET,      // system reset, active high
	output      logic                              SUPPLY_MONITOR_ENABLE, // monitor power enable
	output      logic                              MISSING_CLOCK_ENABLE, // detector enable
	output      logic                              WATCHDOG_ENABLE,   // watchdog enable after reset
	output      logic                              WATCHDOG_TICK      // clock divided by 12 enable
);

	sequence_state_t state_q;
	reset_cause_t    cause_q;
	reset_cause_t    pending_q;
	reset_cause_t    trigger;
	logic            monitor_select_q;
	logic            comparator_select_q;
	logic            clock_loss_select_q;
	logic            bus_select_q;
	logic            software_force;
	logic            vbus_q;
	logic            vbus_edge;
	logic [15:0]     hold_q;
	logic [15:0]     stall_q;
	logic            activity_q;
	logic [3:0]      div_q;
	logic            in_reset;

	function automatic logic hit(input register_access_t a, input logic [7:0] addr);
		hit = a.write_strobe && (a.address == addr);
	endfunction

	assign software_force = hit(REG_ACCESS, `RESET_CAUSE_REGISTER_ADDR) && REG_ACCESS.write_data[`RC_SOFTWARE_BIT];
	// vbus edge of the selected direction
	assign vbus_edge = VBUS_EDGE_POLARITY ? (VBUS_LEVEL && !vbus_q) : (!VBUS_LEVEL && vbus_q);
	assign in_reset = (state_q != SEQ_RUN);

	always_comb begin
		trigger            = '0;
		// our own power-on drive of the pin must not read back as an external pin reset
		trigger.pin        = !RESET_PIN_B_IN && RESET_PIN_OE_B;
		trigger.power_on   = monitor_select_q && SUPPLY_MONITOR_ENABLE && !SUPPLY_ABOVE_THRESHOLD;
		trigger.clock_loss = clock_loss_select_q && (stall_q >= 16'(TIMEOUT_TICKS));
		trigger.watchdog   = WATCHDOG_OVERFLOW;
		trigger.software   = software_force;
		trigger.comparator = comparator_select_q && !COMPARATOR_OUTPUT;
		trigger.memory     = MEMORY_ACCESS_ERROR;
		trigger.bus        = bus_select_q && ((BUS_RESET_SIGNALLING && BUS_CONTROLLER_ENABLED) || vbus_edge);
	end

	always_ff @(posedge CLOCK) begin
		vbus_q <= VBUS_LEVEL;
	end

	// activity watch: any level stuck beyond the time-out counts as a lost clock
	always_ff @(posedge CLOCK) begin
		activity_q <= CLOCK_ACTIVITY;
		if (!RST_B || in_reset || (CLOCK_ACTIVITY != activity_q)) begin
			stall_q <= 16'h0000;
		end else if (stall_q != 16'hFFFF) begin
			stall_q <= stall_q + 16'h0001;
		end
	end

	// sequencer: pending takes the triggers at entry; while held only a pin source replaces it
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			state_q   <= SEQ_HOLD;
			hold_q    <= 16'h0000;
			pending_q <= '0;
			pending_q.power_on <= 1'b1;
		end else begin
			case (state_q)
				SEQ_RUN: begin
					if (trigger != '0) begin
						state_q   <= SEQ_HOLD;
						hold_q    <= 16'h0000;
						pending_q <= trigger;
					end
				end
				SEQ_HOLD: begin
					// a source other than software still asserted keeps the device held
					if ((trigger & ~reset_cause_t'{software: 1'b1, default: 1'b0}) != '0) begin
						hold_q    <= 16'h0000;
						pending_q <= trigger.pin ? reset_cause_t'{pin: 1'b1, default: 1'b0} : pending_q;
					end else if (hold_q >= 16'(HOLD_CYCLES - 1)) begin
						state_q <= SEQ_RELEASE;
					end else begin
						hold_q <= hold_q + 16'h0001;
					end
				end
				SEQ_RELEASE: begin
					state_q <= SEQ_RUN;
				end
				default: begin
					state_q <= SEQ_HOLD;
				end
			endcase
		end
	end

	// cause flags: only the sources latched for the latest reset read 1
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			cause_q <= '0;
		end else if (state_q == SEQ_RELEASE) begin
			cause_q <= pending_q;
		end
	end

	// source selects; every reset drops them except the kept monitor enable
	always_ff @(posedge CLOCK) begin
		if (!RST_B || in_reset) begin
			monitor_select_q    <= 1'b0;
			comparator_select_q <= 1'b0;
			clock_loss_select_q <= 1'b0;
			bus_select_q        <= 1'b0;
		end else if (hit(REG_ACCESS, `RESET_CAUSE_REGISTER_ADDR)) begin
			monitor_select_q    <= REG_ACCESS.write_data[`RC_POWER_ON_BIT];
			comparator_select_q <= REG_ACCESS.write_data[`RC_COMPARATOR_BIT];
			clock_loss_select_q <= REG_ACCESS.write_data[`RC_CLOCK_LOSS_BIT];
			bus_select_q        <= REG_ACCESS.write_data[`RC_BUS_BIT];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			SUPPLY_MONITOR_ENABLE <= 1'b1;
		end else if (hit(REG_ACCESS, `SUPPLY_MONITOR_CONTROL_ADDR)) begin
			SUPPLY_MONITOR_ENABLE <= REG_ACCESS.write_data[`SMC_ENABLE_BIT];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			REG_READ_DATA <= 8'h00;
		end else if (REG_ACCESS.read_strobe) begin
			case (REG_ACCESS.address)
				`SUPPLY_MONITOR_CONTROL_ADDR: begin
					REG_READ_DATA <= {SUPPLY_MONITOR_ENABLE, SUPPLY_ABOVE_THRESHOLD, 6'h00};
				end
				`RESET_CAUSE_REGISTER_ADDR: begin
					REG_READ_DATA <= {cause_q.bus, cause_q.memory, cause_q.comparator, cause_q.software,
						cause_q.watchdog, cause_q.clock_loss, cause_q.power_on, cause_q.pin};
				end
				default: begin
					REG_READ_DATA <= 8'h00;
				end
			endcase
		end
	end

	// only power-on and monitor resets pull the pin; internal sources leave it alone
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			RESET_PIN_B_OUT <= 1'b0;
			RESET_PIN_OE_B  <= 1'b0;
		end else begin
			RESET_PIN_B_OUT <= 1'b0;
			RESET_PIN_OE_B  <= !(in_reset && pending_q.power_on);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			SYSTEM_RESET <= 1'b1;
		end else begin
			SYSTEM_RESET <= (trigger != '0) || (state_q == SEQ_HOLD);
		end
	end

	always_ff @(posedge CLOCK) begin
		MISSING_CLOCK_ENABLE <= RST_B && !in_reset && clock_loss_select_q;
	end

	// watchdog restarts enabled on the divided clock whenever a reset is held
	always_ff @(posedge CLOCK) begin
		if (!RST_B || in_reset) begin
			WATCHDOG_ENABLE <= 1'b1;
			div_q           <= 4'h0;
			WATCHDOG_TICK   <= 1'b0;
		end else begin
			WATCHDOG_ENABLE <= 1'b1;
			WATCHDOG_TICK   <= (div_q == 4'(`WATCHDOG_CLOCK_DIVIDE - 1));
			div_q           <= (div_q == 4'(`WATCHDOG_CLOCK_DIVIDE - 1)) ? 4'h0 : div_q + 4'h1;
		end
	end

endmodule

// file: reset_source_sva.sv
// concurrent checks on the reset source controller ports
`timescale 1ns/1ns
module reset_source_sva
	import reset_source_pkg::*;
(
	input wire logic                               CLOCK,                  // system clock
	input wire logic                               RST_B,                  // power-on reset
	input wire reset_source_pkg::register_access_t REG_ACCESS,             // register request
	input wire logic [7:0]                         REG_READ_DATA,          // read data
	input wire logic                               RESET_PIN_B_IN,         // pin level
	input wire logic                               RESET_PIN_OE_B,         // pin drive enable
	input wire logic                               SUPPLY_ABOVE_THRESHOLD, // monitor output
	input wire logic                               SYSTEM_RESET,           // system reset
	input wire logic                               SUPPLY_MONITOR_ENABLE,  // monitor enable
	input wire logic                               WATCHDOG_ENABLE,        // watchdog enable
	input wire logic                               WATCHDOG_TICK           // divided tick
);
	logic [3:0] gap_q;
	logic       cause_wr;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	assign cause_wr = REG_ACCESS.write_strobe && REG_ACCESS.address == 8'hEF;
	// 4'hF marks an unknown phase, so the first tick after a reset is not judged
	always_ff @(posedge CLOCK) begin
		if (!RST_B || SYSTEM_RESET) gap_q <= 4'hF;
		else if (WATCHDOG_TICK) gap_q <= 4'h0;
		else if (gap_q < 4'hC) gap_q <= gap_q + 4'h1;
	end
	chk_pin_resets_sys: assert property (RESET_PIN_OE_B && !RESET_PIN_B_IN |-> ##[1:2] SYSTEM_RESET)
		else $error("low pin did not reset");
	chk_pin_left_free: assert property (SYSTEM_RESET && SUPPLY_ABOVE_THRESHOLD && $past(RESET_PIN_OE_B) |-> RESET_PIN_OE_B)
		else $error("internal reset drove the pin");
	chk_force_reset: assert property (cause_wr && REG_ACCESS.write_data[4] && !SYSTEM_RESET |=> SYSTEM_RESET)
		else $error("software force ignored");
	chk_reset_min_len: assert property ($rose(SYSTEM_RESET) |=> SYSTEM_RESET [*3])
		else $error("reset too short");
	chk_wdog_enabled: assert property ($fell(SYSTEM_RESET) |-> WATCHDOG_ENABLE)
		else $error("watchdog off after reset");
	chk_tick_period: assert property (WATCHDOG_TICK && !SYSTEM_RESET && gap_q != 4'hF |-> gap_q == 4'hB)
		else $error("tick early");
	chk_tick_no_gap: assert property (gap_q != 4'hC)
		else $error("tick missing");
	chk_mon_on_por: assert property ($rose(RST_B) |-> SUPPLY_MONITOR_ENABLE)
		else $error("monitor off after power-on");
	chk_mon_kept: assert property (SYSTEM_RESET && $past(SYSTEM_RESET) |-> $stable(SUPPLY_MONITOR_ENABLE))
		else $error("monitor enable changed by reset");
	chk_status_read: assert property (REG_ACCESS.read_strobe && REG_ACCESS.address == 8'hFF |=>
		REG_READ_DATA[7:6] == {$past(SUPPLY_MONITOR_ENABLE), $past(SUPPLY_ABOVE_THRESHOLD)})
		else $error("monitor control read wrong");
	cover property ($fell(SYSTEM_RESET));
	cover property (!RESET_PIN_OE_B && SYSTEM_RESET);
	cover property (WATCHDOG_TICK && gap_q == 4'hB);
endmodule
bind reset_source_controller reset_source_sva i_sva (.CLOCK, .RST_B, .REG_ACCESS, .REG_READ_DATA, .RESET_PIN_B_IN,
	.RESET_PIN_OE_B, .SUPPLY_ABOVE_THRESHOLD, .SYSTEM_RESET, .SUPPLY_MONITOR_ENABLE, .WATCHDOG_ENABLE, .WATCHDOG_TICK);

// file: reset_far_side.sv
// reset pin with pull-up and oscillator heartbeat outside the controller
`timescale 1ns/1ns
module reset_far_side (
	input  wire logic CLOCK,     // system clock
	input  wire logic pull_low,  // outside circuit pulls the pin
	input  wire logic osc_stop,  // oscillator stalls
	input  wire logic pin_out,   // controller drive value
	input  wire logic pin_oe_b,  // low while controller drives
	output      logic pin_level, // resolved pin
	output      logic activity   // heartbeat
);
	// pull-up wins when nobody drives, so an idle pin never reads low
	assign pin_level = !(pull_low || (!pin_oe_b && !pin_out));
	initial activity = 1'b0;
	always @(posedge CLOCK) activity <= osc_stop ? activity : !activity;
endmodule

// file: reset_source_controller_tb.sv
// self-checking bench for the reset source controller
`timescale 1ns/1ns
module reset_source_controller_tb;
	import reset_source_pkg::*;
	logic CLOCK = 1'b0, RST_B = 1'b0, SUPPLY_ABOVE_THRESHOLD = 1'b1, COMPARATOR_OUTPUT = 1'b1, WATCHDOG_OVERFLOW = 1'b0;
	logic MEMORY_ACCESS_ERROR = 1'b0, BUS_RESET_SIGNALLING = 1'b0, BUS_CONTROLLER_ENABLED = 1'b1, VBUS_LEVEL = 1'b0;
	logic VBUS_EDGE_POLARITY = 1'b1, pull_low = 1'b0, osc_stop = 1'b0, RESET_PIN_B_IN, CLOCK_ACTIVITY, RESET_PIN_B_OUT;
	logic RESET_PIN_OE_B, SYSTEM_RESET, SUPPLY_MONITOR_ENABLE, MISSING_CLOCK_ENABLE, WATCHDOG_ENABLE, WATCHDOG_TICK;
	logic [7:0]       REG_READ_DATA;
	register_access_t REG_ACCESS = '0;
	int               err_total = 0, samples_checked = 0, cycles = 0;
	always #25 CLOCK = !CLOCK;
	reset_far_side i_far (.CLOCK, .pull_low, .osc_stop, .pin_out(RESET_PIN_B_OUT), .pin_oe_b(RESET_PIN_OE_B),
		.pin_level(RESET_PIN_B_IN), .activity(CLOCK_ACTIVITY));
	// short clock-loss time-out keeps the stall scenario brief
	reset_source_controller #(.TIMEOUT_TICKS(3)) i_dut (.CLOCK, .RST_B, .REG_ACCESS, .REG_READ_DATA, .RESET_PIN_B_IN,
		.RESET_PIN_B_OUT, .RESET_PIN_OE_B, .CLOCK_ACTIVITY, .SUPPLY_ABOVE_THRESHOLD, .COMPARATOR_OUTPUT, .WATCHDOG_OVERFLOW,
		.MEMORY_ACCESS_ERROR, .BUS_RESET_SIGNALLING, .BUS_CONTROLLER_ENABLED, .VBUS_LEVEL, .VBUS_EDGE_POLARITY,
		.SYSTEM_RESET, .SUPPLY_MONITOR_ENABLE, .MISSING_CLOCK_ENABLE, .WATCHDOG_ENABLE, .WATCHDOG_TICK);
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		REG_ACCESS <= '{wr, !wr, a, d};
		@(posedge CLOCK);
		REG_ACCESS <= '0;
		#1;
	endtask
	task automatic reset_seen(input logic [7:0] exp);
		int n;
		n = 0;
		while (SYSTEM_RESET !== 1'b1 && n < 20) begin @(posedge CLOCK); #1; n++; end
		chk("reset entered", 8'h01, {7'h00, SYSTEM_RESET});
		while (SYSTEM_RESET !== 1'b0 && n < 80) begin @(posedge CLOCK); #1; n++; end
		access(1'b0, 8'hEF, 8'h00);
		chk("reset cause", exp, REG_READ_DATA);
	endtask
	task automatic quiet(input string what);
		int hits;
		hits = 0;
		repeat (10) begin @(posedge CLOCK); #1; if (SYSTEM_RESET !== 1'b0) hits++; end
		chk(what, 8'h00, hits[7:0]);
	endtask
	task automatic t_monitor;
		access(1'b1, 8'hFF, 8'h3F);
		access(1'b0, 8'hFF, 8'h00);
		chk("monitor off", 8'h40, REG_READ_DATA);
		access(1'b1, 8'hEF, 8'h02);
		@(posedge CLOCK) SUPPLY_ABOVE_THRESHOLD <= 1'b0;
		quiet("disabled monitor reset");
		SUPPLY_ABOVE_THRESHOLD <= 1'b1;
		access(1'b1, 8'hEF, 8'h10);
		reset_seen(8'h10);
		access(1'b0, 8'hFF, 8'h00);
		chk("monitor kept off", 8'h40, REG_READ_DATA);
		access(1'b1, 8'hFF, 8'h80);
		repeat (20) @(posedge CLOCK);
	endtask
	task automatic t_sources;
		logic [7:0] sel [9] = '{8'h10, 8'h00, 8'h20, 8'h00, 8'h00, 8'h04, 8'h80, 8'h80, 8'h02};
		logic [7:0] cau [9] = '{8'h10, 8'h01, 8'h20, 8'h08, 8'h40, 8'h04, 8'h80, 8'h80, 8'h02};
		for (int k = 0; k < 9; k++) begin
			if (sel[k] != 8'h00) access(1'b1, 8'hEF, sel[k]);
			@(posedge CLOCK);
			case (k)
				1: pull_low <= 1'b1;
				2: COMPARATOR_OUTPUT <= 1'b0;
				3: WATCHDOG_OVERFLOW <= 1'b1;
				4: MEMORY_ACCESS_ERROR <= 1'b1;
				5: osc_stop <= 1'b1;
				6: BUS_RESET_SIGNALLING <= 1'b1;
				7: VBUS_LEVEL <= 1'b1;
				8: SUPPLY_ABOVE_THRESHOLD <= 1'b0;
				default: ;
			endcase
			repeat (k == 0 ? 0 : (k == 5 ? 8 : 4)) @(posedge CLOCK);
			{pull_low, WATCHDOG_OVERFLOW, MEMORY_ACCESS_ERROR, osc_stop, BUS_RESET_SIGNALLING} <= 5'h00;
			{COMPARATOR_OUTPUT, SUPPLY_ABOVE_THRESHOLD} <= 2'b11;
			reset_seen(cau[k]);
		end
	endtask
	task automatic t_quiet;
		access(1'b1, 8'hEF, 8'h80);
		@(posedge CLOCK);
		{BUS_CONTROLLER_ENABLED, BUS_RESET_SIGNALLING, VBUS_LEVEL, COMPARATOR_OUTPUT} <= 4'b0100;
		quiet("unqualified reset");
		{BUS_RESET_SIGNALLING, COMPARATOR_OUTPUT} <= 2'b01;
	endtask
	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			stop_test;
		end
	end
	initial begin
		repeat (10) @(posedge CLOCK);
		RST_B <= 1'b1;
		reset_seen(8'h02);
		access(1'b0, 8'hFF, 8'h00);
		chk("monitor after power-on", 8'hC0, REG_READ_DATA);
		t_monitor;
		t_sources;
		t_quiet;
		stop_test;
	end
endmodule
